// >>> mmio_common_pkg.sv
package mmio_common_pkg;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 40;
  localparam int unsigned CHAN_W        = 2;
  localparam int unsigned CHAN_LSB      = 38;
  localparam int unsigned DOM_W         = 4;
  localparam int unsigned DOM_LSB       = 34;
  localparam int unsigned REGION_W      = 2;
  localparam int unsigned REGION_LSB    = 16;
  localparam int unsigned OFFSET_W      = 16;
  localparam int unsigned NUM_DOM       = 16;

  // ----------------------------------------------------------------
  // Common register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_IDENT     = 16'h0000;
  localparam logic [15:0] OFS_CONTROL   = 16'h0008;
  localparam logic [15:0] OFS_ADDR_INFO = 16'h0010;
  localparam logic [15:0] OFS_MEM_SETUP = 16'h0018;
  localparam logic [15:0] OFS_SCRATCH   = 16'h0020;
  localparam logic [15:0] OFS_LOCK_A    = 16'h0028;
  localparam logic [15:0] OFS_LOCK_B    = 16'h0030;
  localparam logic [15:0] OFS_TALLY     = 16'h0038;
  localparam logic [15:0] OFS_INT_BIND  = 16'h0040;
  localparam logic [15:0] OFS_INT_STAT  = 16'h0048;
  localparam logic [15:0] OFS_HASH_CTL  = 16'h0050;
  localparam logic [15:0] OFS_HASH_DAT  = 16'h0058;
  localparam logic [15:0] OFS_PERM      = 16'h0060;
  localparam logic [15:0] COMMON_END    = 16'h0100;

  // ----------------------------------------------------------------
  // Reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [63:0] RST_ZERO      = 64'h0000_0000_0000_0000;
  localparam logic [15:0] RST_PERM      = 16'hFFFF;
  // Interrupt binding: [7:0] target core, [9:8] level, [14:10] event
  localparam int unsigned BIND_CORE_LSB = 0;
  localparam int unsigned BIND_LVL_LSB  = 8;
  localparam int unsigned BIND_EVT_LSB  = 10;
  // Status [0] pending, enable sits at [32]
  localparam int unsigned INT_EN_BIT    = 32;
  // Hash control: [5:0] index, [8] auto increment
  localparam int unsigned HASH_AW       = 6;
  localparam int unsigned HASH_INC_BIT  = 8;
  localparam int unsigned HASH_DW       = 64;
  // Device control: [0] enable
  localparam int unsigned CTL_EN_BIT    = 0;

endpackage

// >>> hash_table_mem.sv
`timescale 1ns/100ps
module hash_table_mem
  import mmio_common_pkg::*;
#(
  parameter int unsigned AW = HASH_AW,
  parameter int unsigned DW = HASH_DW
)(
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  // Registered read data
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    rd_data <= mem[addr];
  end

endmodule // hash_table_mem

// >>> io_device_mmio_common_shim.sv
// Function
// RULE1: Decode a private 40-bit MMIO address space per device.
// RULE2: Channel field selects which co-located device an access targets.
// RULE3: Service-domain field indexes a permission table allowing or refusing access.
// RULE4: Region field selects the service; offset locates the item within it.
// RULE5: Reserved middle address bits are never interpreted.
// RULE6: Control and monitoring registers live in region zero.
// RULE7: Further regions carry protocol services such as descriptor posting.
// RULE8: Device memory requests go to the home core named by attributes.
// RULE9: Device addresses are translated before memory is accessed.
// RULE10: Interrupts are inter-core events: four levels, 32 events each.
// RULE11: Each interrupt has a software-writable binding: core, level, event.
// RULE12: Interrupt status and enable bits allow sharing and coalescing.
// RULE13: Lowest 256 bytes of region zero hold the common registers.
// RULE14: Common registers at eight-byte offsets from 0x0000 to 0x0058. The code also places a permission word at 0x0060.
// RULE15: Scratch and lock words are never used or altered by hardware.
// RULE16: Device information reports the identifier of this device.
// RULE17: Address-layout information reports how address fields are interpreted.
// RULE18: Hash-for-home table control at 0x0050 and data at 0x0058.
// RULE19: Device-specific registers begin at offset 0x100 or above.
// RULE20: Discovery software maps the hub, reads connectivity, then device info.
// RULE21: Unimplemented common offsets read zero and ignore writes.
`timescale 1ns/100ps
module io_device_mmio_common_shim
  import mmio_common_pkg::*;
#(
  parameter logic [CHAN_W-1:0] MY_CHANNEL = '0,
  // Arbitrary identity value
  parameter logic [63:0]       DEVICE_ID  = 64'h0000_0000_0000_0A5A,
  parameter logic [63:0]       MEM_SETUP  = 64'h0000_0000_0000_0000
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // MMIO request from the mesh
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [63:0]       req_wdata,
  // MMIO response
  output logic                   rsp_valid,
  output logic [63:0]            rsp_rdata,
  output logic                   rsp_denied,
  // Device-specific register window
  output logic                   dev_req_valid,
  output logic                   dev_req_write,
  output logic [OFFSET_W-1:0]    dev_req_offset,
  output logic [63:0]            dev_req_wdata,
  input  wire logic [63:0]       dev_rsp_rdata,
  // Protocol regions above region zero
  output logic                   svc_req_valid,
  output logic [REGION_W-1:0]    svc_req_region,
  output logic [OFFSET_W-1:0]    svc_req_offset,
  output logic [63:0]            svc_req_wdata,
  // Device control and interrupt sources
  output logic [63:0]            device_control,
  input  wire logic              int_event,
  // Inter-core interrupt event
  output logic                   irq_valid,
  output logic [7:0]             irq_core,
  output logic [1:0]             irq_level,
  output logic [4:0]             irq_event,
  // Outgoing memory requests, translated and homed
  input  wire logic              mem_req_valid,
  input  wire logic [ADDR_W-1:0] mem_req_io_addr,
  input  wire logic [ADDR_W-1:0] xlat_phys_addr,
  input  wire logic [7:0]        xlat_home_core,
  output logic                   mem_out_valid,
  output logic [ADDR_W-1:0]      mem_out_addr,
  output logic [7:0]             mem_out_home
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [CHAN_W-1:0]   chan;
  logic [DOM_W-1:0]    dom;
  logic [REGION_W-1:0] region;
  logic [OFFSET_W-1:0] offset;
  logic                hit;
  logic                permit;
  logic                reg_acc;
  logic                common_acc;
  logic                wr;

  logic [15:0]         perm_q;

  assign chan   = req_addr[CHAN_LSB +: CHAN_W];       // RULE1
  assign dom    = req_addr[DOM_LSB +: DOM_W];
  // Bits between the domain and region fields are ignored
  assign region = req_addr[REGION_LSB +: REGION_W];   // RULE5
  assign offset = req_addr[OFFSET_W-1:0];             // RULE4
  assign hit    = req_valid && (chan == MY_CHANNEL);  // RULE2
  assign permit = perm_q[dom];                        // RULE3
  assign reg_acc    = hit && permit && (region == '0);          // RULE6
  assign common_acc = reg_acc && (offset < COMMON_END);         // RULE13
  assign wr         = common_acc && req_write;

  // ------------------------------------------------------------
  // Forwarding to device-specific logic
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dev_req_valid  <= 1'b0;
      dev_req_write  <= 1'b0;
      dev_req_offset <= '0;
      dev_req_wdata  <= '0;
      svc_req_valid  <= 1'b0;
      svc_req_region <= '0;
      svc_req_offset <= '0;
      svc_req_wdata  <= '0;
    end
    else
    begin
      dev_req_valid  <= reg_acc && !(offset < COMMON_END);      // RULE19
      dev_req_write  <= req_write;
      dev_req_offset <= offset;
      dev_req_wdata  <= req_wdata;
      svc_req_valid  <= hit && permit && (region != '0);        // RULE7
      svc_req_region <= region;
      svc_req_offset <= offset;
      svc_req_wdata  <= req_wdata;
    end
  end

  // ------------------------------------------------------------
  // Software-owned and control registers
  // ------------------------------------------------------------
  logic [63:0] scratch_q;
  logic [63:0] lock_a_q;
  logic [63:0] lock_b_q;
  logic [63:0] tally_q;
  logic [63:0] ctl_q;
  logic [63:0] bind_q;

  // Scratch and lock words only change on software writes
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      scratch_q <= RST_ZERO;
      lock_a_q  <= RST_ZERO;
      lock_b_q  <= RST_ZERO;
    end
    else if (wr)
    begin
      if (offset == OFS_SCRATCH) scratch_q <= req_wdata;  // RULE15
      if (offset == OFS_LOCK_A)  lock_a_q  <= req_wdata;  // RULE15
      if (offset == OFS_LOCK_B)  lock_b_q  <= req_wdata;  // RULE15
    end
  end

  // Free-running cycle tally, software may preset it
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      tally_q <= RST_ZERO;
    else if (wr && offset == OFS_TALLY)
      tally_q <= req_wdata;
    else
      tally_q <= tally_q + 64'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctl_q  <= RST_ZERO;
      bind_q <= RST_ZERO;
      perm_q <= RST_PERM;
    end
    else if (wr)
    begin
      if (offset == OFS_CONTROL)  ctl_q  <= req_wdata;
      if (offset == OFS_INT_BIND) bind_q <= req_wdata;                 // RULE11
      if (offset == OFS_PERM)     perm_q <= req_wdata[15:0];           // RULE3
    end
  end

  assign device_control = ctl_q;

  // ------------------------------------------------------------
  // Interrupt status, enable and delivery
  // ------------------------------------------------------------
  logic int_pend_q;
  logic int_en_q;
  logic fire;

  // A new event wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      int_pend_q <= 1'b0;
      int_en_q   <= 1'b0;
    end
    else
    begin
      if (int_event)
        int_pend_q <= 1'b1;                                            // RULE12
      else if (wr && offset == OFS_INT_STAT && req_wdata[0])
        int_pend_q <= 1'b0;
      if (wr && offset == OFS_INT_STAT)
        int_en_q <= req_wdata[INT_EN_BIT];                             // RULE12
    end
  end

  // One event per rising of an enabled pending source; coalesces repeats
  logic fired_q;
  assign fire = int_pend_q && int_en_q && !fired_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      fired_q   <= 1'b0;
      irq_valid <= 1'b0;
      irq_core  <= '0;
      irq_level <= '0;
      irq_event <= '0;
    end
    else
    begin
      fired_q   <= int_pend_q && int_en_q;
      irq_valid <= fire;                                               // RULE10
      irq_core  <= bind_q[BIND_CORE_LSB +: 8];                         // RULE11
      irq_level <= bind_q[BIND_LVL_LSB +: 2];                          // RULE10
      irq_event <= bind_q[BIND_EVT_LSB +: 5];                          // RULE10
    end
  end

  // ------------------------------------------------------------
  // Hash-for-home tables
  // ------------------------------------------------------------
  logic [63:0]         hash_ctl_q;
  logic [HASH_AW-1:0]  hash_idx;
  logic                hash_wr;
  logic                hash_acc;
  logic [HASH_DW-1:0]  hash_rdata;

  assign hash_idx = hash_ctl_q[HASH_AW-1:0];
  assign hash_wr  = wr && offset == OFS_HASH_DAT;                      // RULE18
  assign hash_acc = common_acc && offset == OFS_HASH_DAT;

  // Index steps after each data access when auto increment is set
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      hash_ctl_q <= RST_ZERO;
    else if (wr && offset == OFS_HASH_CTL)
      hash_ctl_q <= req_wdata;                                         // RULE18
    else if (hash_acc && hash_ctl_q[HASH_INC_BIT])
      hash_ctl_q[HASH_AW-1:0] <= hash_idx + {{(HASH_AW-1){1'b0}}, 1'b1};
  end

  hash_table_mem #(
    .AW (HASH_AW),
    .DW (HASH_DW)
  ) u_hash (
    .clk     (clk),
    .wr_en   (hash_wr),
    .addr    (hash_idx),
    .wr_data (req_wdata),
    .rd_data (hash_rdata)
  );

  // ------------------------------------------------------------
  // Read response
  // ------------------------------------------------------------
  logic [63:0] rd_mux;
  logic        pend_hash_q;
  logic        pend_dev_q;

  always_comb
  begin
    unique case (offset)
      OFS_IDENT:     rd_mux = DEVICE_ID;                               // RULE16
      OFS_CONTROL:   rd_mux = ctl_q;
      OFS_ADDR_INFO: rd_mux = {32'h0,                                  // RULE17
                              8'(CHAN_W), 8'(DOM_W), 8'(REGION_W), 8'(OFFSET_W)};
      OFS_MEM_SETUP: rd_mux = MEM_SETUP;
      OFS_SCRATCH:   rd_mux = scratch_q;
      OFS_LOCK_A:    rd_mux = lock_a_q;
      OFS_LOCK_B:    rd_mux = lock_b_q;
      OFS_TALLY:     rd_mux = tally_q;
      OFS_INT_BIND:  rd_mux = bind_q;
      OFS_INT_STAT:  rd_mux = {31'h0, int_en_q, 31'h0, int_pend_q};
      OFS_HASH_CTL:  rd_mux = hash_ctl_q;
      OFS_PERM:      rd_mux = {48'h0, perm_q};
      default:       rd_mux = 64'h0;                                   // RULE21
    endcase
  end

  // Common register reads answer one cycle later; hash and device-window reads a cycle after that
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rsp_valid   <= 1'b0;
      rsp_rdata   <= '0;
      rsp_denied  <= 1'b0;
      pend_hash_q <= 1'b0;
      pend_dev_q  <= 1'b0;
    end
    else
    begin
      pend_hash_q <= hash_acc && !req_write;
      pend_dev_q  <= reg_acc && !(offset < COMMON_END) && !req_write;
      rsp_valid   <= 1'b0;
      rsp_denied  <= 1'b0;
      if (pend_hash_q)
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= hash_rdata;
      end
      else if (pend_dev_q)
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dev_rsp_rdata;
      end
      else if (hit && !permit)
      begin
        rsp_valid  <= 1'b1;                                            // RULE3
        rsp_denied <= 1'b1;
        rsp_rdata  <= '0;
      end
      else if (common_acc && !(hash_acc && !req_write))
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= req_write ? 64'h0 : rd_mux;                       // RULE14
      end
    end
  end

  // ------------------------------------------------------------
  // Outgoing memory requests
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mem_out_valid <= 1'b0;
      mem_out_addr  <= '0;
      mem_out_home  <= '0;
    end
    else
    begin
      mem_out_valid <= mem_req_valid && ctl_q[CTL_EN_BIT];
      mem_out_addr  <= xlat_phys_addr;                                 // RULE9
      mem_out_home  <= xlat_home_core;                                 // RULE8
    end
  end

endmodule // io_device_mmio_common_shim

// >>> mmio_common_shim_props.sv
`timescale 1ns/100ps
module mmio_common_shim_props
  import mmio_common_pkg::*;
#(
  parameter logic [CHAN_W-1:0] MY_CHANNEL = '0,
  parameter logic [63:0]       DEVICE_ID  = 64'h0
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Request and response
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              rsp_valid,
  input  wire logic [63:0]       rsp_rdata,
  input  wire logic              rsp_denied,
  // Forwarded requests
  input  wire logic              dev_req_valid,
  input  wire logic              svc_req_valid,
  // Control, interrupt and memory path
  input  wire logic [63:0]       device_control,
  input  wire logic              irq_valid,
  input  wire logic              mem_req_valid,
  input  wire logic [ADDR_W-1:0] xlat_phys_addr,
  input  wire logic              mem_out_valid,
  input  wire logic [ADDR_W-1:0] mem_out_addr
);
  // ----------------------------------------------------------------
  // Region zero request on our channel
  // ----------------------------------------------------------------
  logic hit0;
  assign hit0 = req_valid && req_addr[39:38] == MY_CHANNEL && req_addr[17:16] == 2'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence id_read;
    hit0 && !req_write && req_addr[15:0] == 16'h0000;
  endsequence
  sequence id_answer;
    rsp_valid && (rsp_denied || rsp_rdata == DEVICE_ID);
  endsequence

  deny_with_rsp_a: assert property (rsp_denied |-> rsp_valid)
    else $error("denial without response");
  rsp_cause_a: assert property (rsp_valid |-> $past(req_valid) || $past(req_valid, 2))
    else $error("response without request");
  dev_window_a: assert property (dev_req_valid |-> $past(hit0 && req_addr[15:0] >= 16'h0100))
    else $error("device request outside window");
  svc_region_a: assert property (svc_req_valid |-> $past(req_valid && req_addr[17:16] != 2'h0))
    else $error("service request without region");
  reg0_no_svc_a: assert property (hit0 |=> !svc_req_valid)
    else $error("region zero sent to service");
  mem_fwd_a: assert property (mem_req_valid && device_control[0] |=> mem_out_valid && mem_out_addr == $past(xlat_phys_addr))
    else $error("memory request not forwarded");
  mem_gate_a: assert property (!(mem_req_valid && device_control[0]) |=> !mem_out_valid)
    else $error("memory request not gated");
  ipi_once_a: assert property (irq_valid |=> !irq_valid)
    else $error("interrupt event repeated");
  id_read_a: assert property (id_read |=> id_answer)
    else $error("identity read wrong");
  ctl_write_a: assert property ($changed(device_control) |-> $past(hit0 && req_write && req_addr[15:0] == 16'h0008))
    else $error("control changed without store");

endmodule // mmio_common_shim_props

bind io_device_mmio_common_shim mmio_common_shim_props #(
  .MY_CHANNEL(MY_CHANNEL),
  .DEVICE_ID (DEVICE_ID)
) props_u (
  .clk, .rst_b, .req_valid, .req_write, .req_addr, .rsp_valid, .rsp_rdata,
  .rsp_denied, .dev_req_valid, .svc_req_valid, .device_control, .irq_valid,
  .mem_req_valid, .xlat_phys_addr, .mem_out_valid, .mem_out_addr
);

// >>> dev_side_model.sv
`timescale 1ns/100ps
module dev_side_model
  import mmio_common_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Device-specific register window
  input  wire logic                dev_req_valid,
  input  wire logic                dev_req_write,
  input  wire logic [OFFSET_W-1:0] dev_req_offset,
  input  wire logic [63:0]         dev_req_wdata,
  output logic      [63:0]         dev_rsp_rdata
);
  logic [63:0] word_q = 64'h0;
  logic [63:0] last_q = 64'h0;
  logic        held_q = 1'b0;

  // One register above the common area; idle data toggles
  always_ff @(posedge clk)
  begin
    if (dev_req_valid && dev_req_write && dev_req_offset == 16'h0100)
      word_q <= dev_req_wdata;
    held_q <= dev_req_valid;
    last_q <= dev_rsp_rdata;
  end

  assign dev_rsp_rdata = (dev_req_valid || held_q) ? word_q : ~last_q;

endmodule // dev_side_model

// >>> io_device_mmio_common_shim_tb.sv
`timescale 1ns/100ps
module io_device_mmio_common_shim_tb
  import mmio_common_pkg::*;
;
  localparam logic [1:0]  CH      = 2'h1;
  // Arbitrary identity value
  localparam logic [63:0] DEV_ID  = 64'h0000_0000_0000_C0DE;
  localparam logic [63:0] MEM_VAL = 64'h0000_0000_0000_1234;

  typedef struct packed {logic w; logic [15:0] o; logic [63:0] d; logic [63:0] e;} row_type;

  logic              clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic              int_event = 1'b0, mem_req_valid = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0, mem_req_io_addr = '0, xlat_phys_addr = '0;
  logic [ADDR_W-1:0] mem_out_addr;
  logic [63:0]       req_wdata = '0, rsp_rdata, dev_req_wdata, dev_rsp_rdata, svc_req_wdata, device_control;
  logic [7:0]        xlat_home_core = '0, irq_core, mem_out_home;
  logic              rsp_valid, rsp_denied, dev_req_valid, dev_req_write, svc_req_valid;
  logic              irq_valid, mem_out_valid;
  logic [15:0]       dev_req_offset, svc_req_offset;
  logic [1:0]        svc_req_region, irq_level;
  logic [4:0]        irq_event;
  logic [63:0]       rd, t;
  logic              dn;
  logic [17:0]       sv;
  logic [14:0]       ib;
  int                fails = 0, compares = 0, ipis = 0;

  row_type rows [16] = '{
    '{1'b0, 16'h0000, 64'h0, DEV_ID},
    '{1'b0, 16'h0010, 64'h0, 64'h0000_0000_0204_0210},
    '{1'b0, 16'h0018, 64'h0, MEM_VAL},
    '{1'b0, 16'h0060, 64'h0, 64'h0000_0000_0000_FFFF},
    '{1'b1, 16'h0020, 64'hA5A5_0000_5A5A_FFFF, 64'h0},
    '{1'b0, 16'h0020, 64'h0, 64'hA5A5_0000_5A5A_FFFF},
    '{1'b1, 16'h0028, 64'h0123_4567_89AB_CDEF, 64'h0},
    '{1'b0, 16'h0028, 64'h0, 64'h0123_4567_89AB_CDEF},
    '{1'b1, 16'h0030, 64'hFEDC_BA98_7654_3210, 64'h0},
    '{1'b0, 16'h0030, 64'h0, 64'hFEDC_BA98_7654_3210},
    '{1'b1, 16'h0040, 64'h472A, 64'h0},
    '{1'b0, 16'h0040, 64'h0, 64'h472A},
    '{1'b1, 16'h0008, 64'h1, 64'h0},
    '{1'b0, 16'h0008, 64'h0, 64'h1},
    '{1'b1, 16'h0068, 64'hFF, 64'h0},
    '{1'b0, 16'h0068, 64'h0, 64'h0}
  };

  io_device_mmio_common_shim #(.MY_CHANNEL(CH), .DEVICE_ID(DEV_ID), .MEM_SETUP(MEM_VAL)) dut_u (
    .clk, .rst_b, .req_valid, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .rsp_denied, .dev_req_valid, .dev_req_write, .dev_req_offset, .dev_req_wdata,
    .dev_rsp_rdata, .svc_req_valid, .svc_req_region, .svc_req_offset, .svc_req_wdata,
    .device_control, .int_event, .irq_valid, .irq_core, .irq_level, .irq_event, .mem_req_valid,
    .mem_req_io_addr, .xlat_phys_addr, .xlat_home_core, .mem_out_valid, .mem_out_addr,
    .mem_out_home
  );

  dev_side_model dev_u (.clk, .dev_req_valid, .dev_req_write, .dev_req_offset,
    .dev_req_wdata, .dev_rsp_rdata);

  always #4 clk = ~clk;

  always @(posedge clk)
    if (irq_valid === 1'b1)
    begin
      ipis++;
      ib = {irq_event, irq_level, irq_core};
    end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [39:0] ad(input logic [1:0] rg, input logic [15:0] o);
    return {CH, 4'h2, 16'h0, rg, o};
  endfunction

  task check(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  // One request; answer must come after exactly lat cycles, 0 for none
  task bus(input logic w, input logic [39:0] a, input logic [63:0] d, input int lat);
    int got;
    got = 0;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    for (int i = 1; i < 4; i++)
    begin
      if (rsp_valid === 1'b1)
      begin
        got = i;
        rd = rsp_rdata;
        dn = rsp_denied;
      end
      if (svc_req_valid === 1'b1)
      begin
        sv = {svc_req_region, svc_req_offset};
        t  = svc_req_wdata;
      end
      @(posedge clk);
      #1;
    end
    check("latency", 64'(got), 64'(lat));
  endtask

  task pulse_mem;
    mem_req_valid = 1'b1;
    @(posedge clk);
    #1;
    mem_req_valid = 1'b0;
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check("reset control", device_control, 64'h0);
    foreach (rows[i])
    begin
      bus(rows[i].w, ad(2'h0, rows[i].o), rows[i].d, 1);
      check("row data", rd, rows[i].e);
    end
    bus(1'b0, ad(2'h0, 16'h0038), 64'h0, 1);
    t = rd;
    bus(1'b0, ad(2'h0, 16'h0038), 64'h0, 1);
    check("tally", rd, t + 64'h4);
    bus(1'b1, {2'h2, 4'h2, 16'h0, 2'h0, 16'h0020}, 64'h0BAD, 0);
    bus(1'b0, {CH, 4'h2, 16'hFFFF, 2'h0, 16'h0000}, 64'h0, 1);
    check("reserved bits", rd, DEV_ID);
    bus(1'b1, ad(2'h0, 16'h0060), 64'hFFF7, 1);
    bus(1'b1, {CH, 4'h3, 16'h0, 2'h0, 16'h0020}, 64'h0, 1);
    check("denied", 64'(dn), 64'h1);
    bus(1'b0, ad(2'h0, 16'h0020), 64'h0, 1);
    check("allowed", 64'(dn), 64'h0);
    check("scratch kept", rd, 64'hA5A5_0000_5A5A_FFFF);
    bus(1'b1, ad(2'h0, 16'h0060), 64'hFFFF, 1);
    sv = '0;
    t = '0;
    bus(1'b1, ad(2'h1, 16'h0040), 64'h77, 0);
    check("service", 64'(sv), 64'h1_0040);
    check("service data", t, 64'h77);
    bus(1'b1, ad(2'h0, 16'h0100), 64'h5150, 0);
    bus(1'b0, ad(2'h0, 16'h0100), 64'h0, 2);
    check("device word", rd, 64'h5150);
    bus(1'b1, ad(2'h0, 16'h0050), 64'h5, 1);
    bus(1'b1, ad(2'h0, 16'h0058), 64'hAAAA, 1);
    bus(1'b1, ad(2'h0, 16'h0050), 64'h6, 1);
    bus(1'b1, ad(2'h0, 16'h0058), 64'hBBBB, 1);
    bus(1'b1, ad(2'h0, 16'h0050), 64'h105, 1);
    bus(1'b0, ad(2'h0, 16'h0058), 64'h0, 2);
    check("hash first", rd, 64'hAAAA);
    bus(1'b0, ad(2'h0, 16'h0058), 64'h0, 2);
    check("hash next", rd, 64'hBBBB);
    bus(1'b0, ad(2'h0, 16'h0050), 64'h0, 1);
    check("hash index", rd, 64'h107);
    bus(1'b1, ad(2'h0, 16'h0040), 64'h472A, 1);
    int_event = 1'b1;
    @(posedge clk);
    #1;
    int_event = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("masked", 64'(ipis), 64'h0);
    bus(1'b1, ad(2'h0, 16'h0048), 64'h0000_0001_0000_0000, 1);
    check("event count", 64'(ipis), 64'h1);
    check("binding", 64'(ib), 64'h472A);
    bus(1'b0, ad(2'h0, 16'h0048), 64'h0, 1);
    check("status", rd, 64'h0000_0001_0000_0001);
    bus(1'b1, ad(2'h0, 16'h0048), 64'h0000_0001_0000_0001, 1);
    bus(1'b0, ad(2'h0, 16'h0048), 64'h0, 1);
    check("cleared", rd, 64'h0000_0001_0000_0000);
    check("single event", 64'(ipis), 64'h1);
    xlat_phys_addr = 40'h12_3456_7890;
    xlat_home_core = 8'h1C;
    pulse_mem();
    check("mem valid", 64'(mem_out_valid), 64'h1);
    check("mem addr", 64'(mem_out_addr), 64'h12_3456_7890);
    check("mem home", 64'(mem_out_home), 64'h1C);
    bus(1'b1, ad(2'h0, 16'h0008), 64'h0, 1);
    pulse_mem();
    check("mem gated", 64'(mem_out_valid), 64'h0);
    // Reset in mid-run
    bus(1'b1, ad(2'h0, 16'h0060), 64'hFFF7, 1);
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    bus(1'b0, ad(2'h0, 16'h0060), 64'h0, 1);
    check("reset table", rd, 64'h0000_0000_0000_FFFF);
    bus(1'b0, ad(2'h0, 16'h0020), 64'h0, 1);
    check("reset scratch", rd, 64'h0);
    finish_test();
  end

endmodule // io_device_mmio_common_shim_tb
